// *** hdl/cvc_top.v ***
// chained vectored interrupt controller: two 16-channel units and a fast request
//
// Functional notes
// - 32 channels in; fast and vectored request out; fast has precedence.
// - two chained units; any primary request beats every secondary request.
// - any one of 32 sources may be routed to the fast request.
// - vectored request is the OR of all vectored channel requests.
// - channel 0 highest priority, channel 31 lowest.
// - firmware remaps sources to channels inside one unit only.
// - winner resolved; routine reads source identity and vector address.
// - firmware can force a request on any vectored channel.
// - five sources come from the wake-up unit, 27 from on-chip logic.
// - one wake request ORs 30 pins, clock interrupt and resume.
// - four wake requests each OR a group of eight sources.
// - primary channels 0-3: watchdog, firmware, debug receive, debug transmit.
// - channels 4-7 OR capture, compare and overflow of timers 0-3.
// - channels 8-15: bus high, bus low, clock, MAC, DMA, CAN, motor, ADC.
// - channels 16-23: three serial, two two-wire, two sync serial, voltage warning.
// - channel 24 ORs clock alarm, tamper and periodic interrupts.
`include "cvc_defines.vh"

module cvc_top #(
	parameter NCH = `CVC_NUM_CH,
	parameter UCH = `CVC_UNIT_CH,
	parameter UIW = `CVC_UNIT_IW
) (
	// clock and reset
	input  wire                 CLK,
	input  wire                 RST,
	// processor core and firmware sources
	input  wire                 WATCHDOG_UNIT_IRQ,
	input  wire                 FIRMWARE_IRQ,
	input  wire                 DEBUG_RX_IRQ,
	input  wire                 DEBUG_TX_IRQ,
	// timers, two capture and two compare events and one overflow per timer
	input  wire [7:0]           TIMER_CAPTURE_EVENT,
	input  wire [7:0]           TIMER_COMPARE_EVENT,
	input  wire [3:0]           TIMER_OVERFLOW,
	// primary unit peripherals
	input  wire                 USB_HI_IRQ,
	input  wire                 USB_LO_IRQ,
	input  wire                 CLOCK_CONTROL_UNIT_IRQ,
	input  wire                 MAC_IRQ,
	input  wire [7:0]           DMA_IRQ,
	input  wire                 CAN_IRQ,
	input  wire [7:0]           MOTOR_CONTROL_UNIT_IRQ,
	input  wire                 ADC_DONE_IRQ,
	// secondary unit peripherals
	input  wire [14:0]          UART_IRQ,
	input  wire [5:0]           TWI_IRQ,
	input  wire [1:0]           SYNC_SERIAL_PORT_IRQ,
	input  wire                 LOW_VOLTAGE_WARNING_IRQ,
	input  wire                 RTC_ALARM_IRQ,
	input  wire                 RTC_TAMPER_IRQ,
	input  wire                 RTC_PERIODIC_IRQ,
	input  wire [1:0]           SPARE_IRQ,
	// wake-up unit
	input  wire [29:0]          WAKE_PIN,
	input  wire                 WAKE_RTC,
	input  wire                 WAKE_RESUME,
	// firmware control
	input  wire [NCH-1:0]       SRC_ENABLE,
	input  wire [NCH-1:0]       FORCE_CH,
	input  wire                 FAST_EN,
	input  wire [4:0]           FAST_SEL,
	input  wire [UCH*UIW-1:0]   PRI_CHAN_MAP,
	input  wire [UCH*UIW-1:0]   SEC_CHAN_MAP,
	input  wire [31:0]          VECTOR_BASE,
	// requests to the processor
	output reg                  FAST_REQUEST_OUT,
	output reg                  VECTOR_REQUEST_OUT,
	output reg  [4:0]           ACTIVE_SOURCE,
	output reg  [31:0]          VECTOR_ADDR
);

	// ---------------------------------------------------------------
	// wake pin synchronisers
	// ---------------------------------------------------------------
	reg  [29:0] wake_meta_r;
	reg  [29:0] wake_sync_r;

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			wake_meta_r <= 30'h00000000;
			wake_sync_r <= 30'h00000000;
		end else begin
			wake_meta_r <= WAKE_PIN;
			wake_sync_r <= wake_meta_r;
		end
	end

	// ---------------------------------------------------------------
	// source vector
	// ---------------------------------------------------------------
	wire [NCH-1:0] src_raw;
	wire [3:0]     wake_grp;
	wire           wake_all;

	assign wake_all    = |wake_sync_r | WAKE_RTC | WAKE_RESUME;
	assign wake_grp[0] = |wake_sync_r[`CVC_WK_P3_LSB +: `CVC_WK_P3_W] | WAKE_RTC | WAKE_RESUME;
	assign wake_grp[1] = |wake_sync_r[`CVC_WK_P5_LSB +: `CVC_WK_PORT_W];
	assign wake_grp[2] = |wake_sync_r[`CVC_WK_P6_LSB +: `CVC_WK_PORT_W];
	assign wake_grp[3] = |wake_sync_r[`CVC_WK_P7_LSB +: `CVC_WK_PORT_W];

	assign src_raw[`CVC_CH_WDOG]   = WATCHDOG_UNIT_IRQ;
	assign src_raw[`CVC_CH_SOFT]   = FIRMWARE_IRQ;
	assign src_raw[`CVC_CH_DBG_RX] = DEBUG_RX_IRQ;
	assign src_raw[`CVC_CH_DBG_TX] = DEBUG_TX_IRQ;

	genvar t;
	generate
		for (t = 0; t < 4; t = t + 1) begin : g_tmr
			assign src_raw[`CVC_CH_TMR0 + t] = |TIMER_CAPTURE_EVENT[2*t +: 2] |
				|TIMER_COMPARE_EVENT[2*t +: 2] | TIMER_OVERFLOW[t];
		end
		for (t = 0; t < 3; t = t + 1) begin : g_uart
			assign src_raw[`CVC_CH_UART0 + t] = |UART_IRQ[5*t +: 5];
		end
		for (t = 0; t < 2; t = t + 1) begin : g_two
			assign src_raw[`CVC_CH_TWI0 + t]  = |TWI_IRQ[3*t +: 3];
			assign src_raw[`CVC_CH_SYNC_SERIAL_PORT + t]  = SYNC_SERIAL_PORT_IRQ[t];
			assign src_raw[`CVC_CH_SPARE0 + t] = SPARE_IRQ[t];
		end
		for (t = 0; t < 4; t = t + 1) begin : g_wake
			assign src_raw[`CVC_CH_WAKE_G0 + t] = wake_grp[t];
		end
	endgenerate

	assign src_raw[`CVC_CH_USB_HI]   = USB_HI_IRQ;
	assign src_raw[`CVC_CH_USB_LO]   = USB_LO_IRQ;
	assign src_raw[`CVC_CH_CLK]      = CLOCK_CONTROL_UNIT_IRQ;
	assign src_raw[`CVC_CH_MAC]      = MAC_IRQ;
	assign src_raw[`CVC_CH_DMA]      = |DMA_IRQ;
	assign src_raw[`CVC_CH_CAN]      = CAN_IRQ;
	assign src_raw[`CVC_CH_MOTOR]    = |MOTOR_CONTROL_UNIT_IRQ;
	assign src_raw[`CVC_CH_ADC]      = ADC_DONE_IRQ;
	assign src_raw[`CVC_CH_LVW]      = LOW_VOLTAGE_WARNING_IRQ;
	assign src_raw[`CVC_CH_RTC]      = RTC_ALARM_IRQ | RTC_TAMPER_IRQ | RTC_PERIODIC_IRQ;
	assign src_raw[`CVC_CH_WAKE_ALL] = wake_all;

	// ---------------------------------------------------------------
	// fast path and vectored gating
	// ---------------------------------------------------------------
	wire [NCH-1:0] src_en;
	wire [NCH-1:0] fast_mask;
	wire [NCH-1:0] vec_src;
	wire           fast_req;

	// levels only: nothing latched, a source clearing drops the request
	assign src_en    = src_raw & SRC_ENABLE;
	assign fast_mask = FAST_EN ? ({{(NCH-1){1'b0}}, 1'b1} << FAST_SEL) : {NCH{1'b0}};
	assign fast_req  = |(src_en & fast_mask);
	// a source owned by the fast path never also raises a vectored request
	assign vec_src   = src_en & ~fast_mask;

	// ---------------------------------------------------------------
	// primary and secondary units
	// ---------------------------------------------------------------
	wire           pri_any;
	wire           sec_any;
	wire [UIW-1:0] pri_ch;
	wire [UIW-1:0] sec_ch;
	wire [UIW-1:0] pri_src;
	wire [UIW-1:0] sec_src;

	cvc_vec_unit #(.N(UCH), .IW(UIW)) u_primary_vector_unit (
		.src      (vec_src[UCH-1:0]),
		.chan_map (PRI_CHAN_MAP),
		.force_ch (FORCE_CH[UCH-1:0]),
		.any_req  (pri_any),
		.win_ch   (pri_ch),
		.win_src  (pri_src)
	);

	cvc_vec_unit #(.N(UCH), .IW(UIW)) u_secondary_vector_unit (
		.src      (vec_src[NCH-1:UCH]),
		.chan_map (SEC_CHAN_MAP),
		.force_ch (FORCE_CH[NCH-1:UCH]),
		.any_req  (sec_any),
		.win_ch   (sec_ch),
		.win_src  (sec_src)
	);

	// ---------------------------------------------------------------
	// chain resolve and output registers
	// ---------------------------------------------------------------
	wire        sel_sec;
	wire [4:0]  win_chan;
	wire [4:0]  src_nxt;
	wire [31:0] vaddr_nxt;

	assign sel_sec   = ~pri_any;
	assign win_chan  = sel_sec ? {1'b1, sec_ch} : {1'b0, pri_ch};
	assign src_nxt   = sel_sec ? {1'b1, sec_src} : {1'b0, pri_src};
	assign vaddr_nxt = VECTOR_BASE + {25'h0000000, win_chan, 2'h0};

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			FAST_REQUEST_OUT   <= 1'b0;
			VECTOR_REQUEST_OUT <= 1'b0;
			ACTIVE_SOURCE      <= `CVC_SRC_RST;
			VECTOR_ADDR        <= `CVC_VADDR_RST;
		end else begin
			FAST_REQUEST_OUT   <= fast_req;
			VECTOR_REQUEST_OUT <= pri_any | sec_any;
			// identity and address hold the last winner once requests drop
			if (pri_any | sec_any) begin
				ACTIVE_SOURCE <= src_nxt;
				VECTOR_ADDR   <= vaddr_nxt;
			end
		end
	end

endmodule // cvc_top

// *** hdl/cvc_defines.vh ***
// constants for the chained vectored interrupt controller
`ifndef CVC_DEFINES_VH
`define CVC_DEFINES_VH

// ---------------------------------------------------------------
// channel counts
// ---------------------------------------------------------------
`define CVC_NUM_CH      32
`define CVC_UNIT_CH     16
`define CVC_UNIT_IW     4
`define CVC_WAKE_PINS   30
`define CVC_SYNC_STAGES 2

// ---------------------------------------------------------------
// channel positions in the combined source vector
// ---------------------------------------------------------------
`define CVC_CH_WDOG     0
`define CVC_CH_SOFT     1
`define CVC_CH_DBG_RX   2
`define CVC_CH_DBG_TX   3
`define CVC_CH_TMR0     4
`define CVC_CH_USB_HI   8
`define CVC_CH_USB_LO   9
`define CVC_CH_CLK      10
`define CVC_CH_MAC      11
`define CVC_CH_DMA      12
`define CVC_CH_CAN      13
`define CVC_CH_MOTOR    14
`define CVC_CH_ADC      15
`define CVC_CH_UART0    16
`define CVC_CH_TWI0     19
`define CVC_CH_SYNC_SERIAL_PORT     21
`define CVC_CH_LVW      23
`define CVC_CH_RTC      24
`define CVC_CH_WAKE_ALL 25
`define CVC_CH_WAKE_G0  26
`define CVC_CH_SPARE0   30

// ---------------------------------------------------------------
// wake pin layout: [5:0] port3 pins 2..7, then ports 5, 6, 7
// ---------------------------------------------------------------
`define CVC_WK_P3_LSB   0
`define CVC_WK_P3_W     6
`define CVC_WK_P5_LSB   6
`define CVC_WK_P6_LSB   14
`define CVC_WK_P7_LSB   22
`define CVC_WK_PORT_W   8

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define CVC_SRC_RST     5'h00
`define CVC_VADDR_RST   32'h00000000

`endif

// *** hdl/cvc_vec_unit.v ***
// one 16-channel vectored unit: remap, force and priority resolve
`include "cvc_defines.vh"

module cvc_vec_unit #(
	parameter N  = `CVC_UNIT_CH,
	parameter IW = `CVC_UNIT_IW
) (
	input  wire [N-1:0]    src,
	input  wire [N*IW-1:0] chan_map,
	input  wire [N-1:0]    force_ch,
	output reg             any_req,
	output reg  [IW-1:0]   win_ch,
	output reg  [IW-1:0]   win_src
);

	wire [N-1:0] chan_req;
	integer      k;

	// ---------------------------------------------------------------
	// per channel source selection
	// ---------------------------------------------------------------
	genvar c;
	generate
		for (c = 0; c < N; c = c + 1) begin : g_ch
			// any source may sit on any channel of this unit
			assign chan_req[c] = src[chan_map[c*IW +: IW]] | force_ch[c];
		end
	endgenerate

	// ---------------------------------------------------------------
	// lowest channel index wins
	// ---------------------------------------------------------------
	always @* begin
		any_req = |chan_req;
		win_ch  = {IW{1'b0}};
		win_src = {IW{1'b0}};
		for (k = N - 1; k >= 0; k = k - 1) begin
			if (chan_req[k]) begin
				win_ch  = k[IW-1:0];
				win_src = chan_map[k*IW +: IW];
			end
		end
	end

endmodule // cvc_vec_unit

// *** bench/cvc_checker.sv ***
// port-level assertions for the chained vectored interrupt controller
module cvc_checker #(
	parameter NCH = 32,
	parameter UCH = 16,
	parameter UIW = 4
) (
	// clock and reset
	input wire           CLK,
	input wire           RST,
	// watched inputs
	input wire           WATCHDOG_UNIT_IRQ,
	input wire [29:0]    WAKE_PIN,
	input wire [NCH-1:0] SRC_ENABLE,
	input wire [NCH-1:0] FORCE_CH,
	input wire           FAST_EN,
	input wire [4:0]     FAST_SEL,
	input wire [31:0]    VECTOR_BASE,
	// watched outputs
	input wire           FAST_REQUEST_OUT,
	input wire           VECTOR_REQUEST_OUT,
	input wire [4:0]     ACTIVE_SOURCE,
	input wire [31:0]    VECTOR_ADDR
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	property p_fast_route;
		FAST_EN && FAST_SEL == 5'h00 && WATCHDOG_UNIT_IRQ |=> FAST_REQUEST_OUT;
	endproperty
	property p_fast_idle;
		!FAST_EN |=> !FAST_REQUEST_OUT;
	endproperty
	property p_force0;
		FORCE_CH[0] && !FAST_EN |=> VECTOR_REQUEST_OUT && VECTOR_ADDR == $past(VECTOR_BASE);
	endproperty
	property p_force31;
		FORCE_CH == 32'h80000000 && SRC_ENABLE == 32'h0 |=> ACTIVE_SOURCE == 5'h1f && VECTOR_ADDR == $past(VECTOR_BASE) + 32'h7c;
	endproperty
	property p_quiet;
		SRC_ENABLE == 32'h0 && FORCE_CH == 32'h0 |=> !VECTOR_REQUEST_OUT;
	endproperty
	property p_wdog;
		WATCHDOG_UNIT_IRQ && SRC_ENABLE[0] && !FAST_EN |=> ACTIVE_SOURCE == 5'h00 && VECTOR_ADDR == $past(VECTOR_BASE);
	endproperty
	// pins pass two sync flops, so three edges of steady level
	property p_wake;
		(WAKE_PIN != 30'h0)[*3] ##0 (SRC_ENABLE[25:0] == 26'h2000000 && FORCE_CH == 32'h0 && !FAST_EN) |=> ACTIVE_SOURCE == 5'h19;
	endproperty
	property p_hold;
		!VECTOR_REQUEST_OUT ##1 !VECTOR_REQUEST_OUT |-> $stable(ACTIVE_SOURCE) && $stable(VECTOR_ADDR);
	endproperty
	a_fast_route: assert property (p_fast_route) else $error("fast request missing");
	a_fast_idle: assert property (p_fast_idle) else $error("fast request while disabled");
	a_force0: assert property (p_force0) else $error("forced channel 0 not on top");
	a_force31: assert property (p_force31) else $error("forced channel 31 wrong");
	a_quiet: assert property (p_quiet) else $error("vectored request with nothing enabled");
	a_wdog: assert property (p_wdog) else $error("watchdog not first");
	a_wake: assert property (p_wake) else $error("wake summary source wrong");
	a_hold: assert property (p_hold) else $error("winner changed while idle");
	c_fast: cover property (FAST_REQUEST_OUT && !VECTOR_REQUEST_OUT);
	c_vec: cover property ($rose(VECTOR_REQUEST_OUT));
	c_wake: cover property (ACTIVE_SOURCE == 5'h19 && VECTOR_REQUEST_OUT);
endmodule // cvc_checker

bind cvc_top cvc_checker #(.NCH(NCH), .UCH(UCH), .UIW(UIW)) u_chk (.CLK(CLK), .RST(RST),
	.WATCHDOG_UNIT_IRQ(WATCHDOG_UNIT_IRQ), .WAKE_PIN(WAKE_PIN), .SRC_ENABLE(SRC_ENABLE), .FORCE_CH(FORCE_CH),
	.FAST_EN(FAST_EN), .FAST_SEL(FAST_SEL), .VECTOR_BASE(VECTOR_BASE), .FAST_REQUEST_OUT(FAST_REQUEST_OUT),
	.VECTOR_REQUEST_OUT(VECTOR_REQUEST_OUT), .ACTIVE_SOURCE(ACTIVE_SOURCE), .VECTOR_ADDR(VECTOR_ADDR));

// *** bench/cvc_core_model.sv ***
// core-side model: the service routine reads source and vector
module cvc_core_model (
	// clock and reset
	input wire          CLK,
	input wire          RST,
	// controller answers
	input wire          VECTOR_REQUEST_OUT,
	input wire [4:0]    ACTIVE_SOURCE,
	input wire [31:0]   VECTOR_ADDR,
	// what the routine read
	output logic [4:0]  read_src_r,
	output logic [31:0] read_addr_r
);
	timeunit 1ns;
	timeprecision 1ps;
	// reads only while the request stands, as a real handler would
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			read_src_r <= 5'h00;
			read_addr_r <= 32'h0;
		end else if (VECTOR_REQUEST_OUT) begin
			read_src_r <= ACTIVE_SOURCE;
			read_addr_r <= VECTOR_ADDR;
		end
	end
endmodule // cvc_core_model

// *** bench/cvc_top_test.sv ***
// self-checking bench for the chained vectored interrupt controller
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin fails++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module cvc_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] BASE = 32'h00001000;
	logic CLK = 0, RST = 1, WATCHDOG_UNIT_IRQ = 0, FIRMWARE_IRQ = 0, DEBUG_RX_IRQ = 0, DEBUG_TX_IRQ = 0, USB_HI_IRQ = 0;
	logic USB_LO_IRQ = 0, CLOCK_CONTROL_UNIT_IRQ = 0, MAC_IRQ = 0, CAN_IRQ = 0, ADC_DONE_IRQ = 0, RTC_ALARM_IRQ = 0;
	logic LOW_VOLTAGE_WARNING_IRQ = 0, RTC_TAMPER_IRQ = 0, RTC_PERIODIC_IRQ = 0, WAKE_RTC = 0, WAKE_RESUME = 0;
	logic [7:0] TIMER_CAPTURE_EVENT = '0, TIMER_COMPARE_EVENT = '0, DMA_IRQ = '0, MOTOR_CONTROL_UNIT_IRQ = '0;
	logic [3:0] TIMER_OVERFLOW = '0;
	logic [14:0] UART_IRQ = '0;
	logic [5:0] TWI_IRQ = '0;
	logic [1:0] SYNC_SERIAL_PORT_IRQ = '0, SPARE_IRQ = '0;
	logic [29:0] WAKE_PIN = '0;
	logic [31:0] SRC_ENABLE = '1, FORCE_CH = '0, VECTOR_BASE = BASE, VECTOR_ADDR, read_addr_r;
	logic FAST_EN = 0, FAST_REQUEST_OUT, VECTOR_REQUEST_OUT;
	logic [4:0] FAST_SEL = '0, ACTIVE_SOURCE, read_src_r;
	logic [63:0] PRI_CHAN_MAP = '0, SEC_CHAN_MAP = '0;
	int fails = 0, samples_checked = 0;
	cvc_top u_dut (.CLK, .RST, .WATCHDOG_UNIT_IRQ, .FIRMWARE_IRQ, .DEBUG_RX_IRQ, .DEBUG_TX_IRQ, .TIMER_CAPTURE_EVENT,
		.TIMER_COMPARE_EVENT, .TIMER_OVERFLOW, .USB_HI_IRQ, .USB_LO_IRQ, .CLOCK_CONTROL_UNIT_IRQ, .MAC_IRQ, .DMA_IRQ,
		.CAN_IRQ, .MOTOR_CONTROL_UNIT_IRQ, .ADC_DONE_IRQ, .UART_IRQ, .TWI_IRQ, .SYNC_SERIAL_PORT_IRQ,
		.LOW_VOLTAGE_WARNING_IRQ, .RTC_ALARM_IRQ, .RTC_TAMPER_IRQ, .RTC_PERIODIC_IRQ, .SPARE_IRQ, .WAKE_PIN, .WAKE_RTC,
		.WAKE_RESUME, .SRC_ENABLE, .FORCE_CH, .FAST_EN, .FAST_SEL, .PRI_CHAN_MAP, .SEC_CHAN_MAP, .VECTOR_BASE,
		.FAST_REQUEST_OUT, .VECTOR_REQUEST_OUT, .ACTIVE_SOURCE, .VECTOR_ADDR);
	cvc_core_model u_core (.CLK, .RST, .VECTOR_REQUEST_OUT, .ACTIVE_SOURCE, .VECTOR_ADDR, .read_src_r, .read_addr_r);
	always #5 CLK = ~CLK;
	// one edge, then winner and its vector
	task step(input logic [4:0] e);
		@(negedge CLK);
		`CHK("source", e, ACTIVE_SOURCE)
		`CHK("vector", BASE + {25'h0, e, 2'b00}, VECTOR_ADDR)
	endtask
	task t_walk();
		ADC_DONE_IRQ = 1;
		step(5'h0f);
		`CHK("vreq", 1'b1, VECTOR_REQUEST_OUT)
		WATCHDOG_UNIT_IRQ = 1;
		step(5'h00);
		ADC_DONE_IRQ = 0;
		WATCHDOG_UNIT_IRQ = 0;
		@(negedge CLK);
		`CHK("vreq", 1'b0, VECTOR_REQUEST_OUT)
	endtask
	task t_chain();
		UART_IRQ[14] = 1;
		CAN_IRQ = 1;
		step(5'h0d);
		CAN_IRQ = 0;
		step(5'h12);
		@(negedge CLK);
		`CHK("core read", 5'h12, read_src_r)
		UART_IRQ = '0;
	endtask
	task t_fast();
		FAST_EN = 1;
		WATCHDOG_UNIT_IRQ = 1;
		@(negedge CLK);
		`CHK("fast", 1'b1, FAST_REQUEST_OUT)
		`CHK("vreq", 1'b0, VECTOR_REQUEST_OUT)
		TIMER_OVERFLOW[1] = 1;
		step(5'h05);
		WATCHDOG_UNIT_IRQ = 0;
		TIMER_OVERFLOW = '0;
		FAST_EN = 0;
		@(negedge CLK);
		`CHK("fast", 1'b0, FAST_REQUEST_OUT)
	endtask
	task t_remap();
		PRI_CHAN_MAP[7:4] = 4'hf;
		PRI_CHAN_MAP[63:60] = 4'h1;
		FIRMWARE_IRQ = 1;
		ADC_DONE_IRQ = 1;
		@(negedge CLK);
		`CHK("source", 5'h0f, ACTIVE_SOURCE)
		`CHK("vector", BASE + 32'h4, VECTOR_ADDR)
		PRI_CHAN_MAP[7:4] = 4'h1;
		PRI_CHAN_MAP[63:60] = 4'hf;
		FIRMWARE_IRQ = 0;
		SRC_ENABLE = '0;
		@(negedge CLK);
		`CHK("vreq", 1'b0, VECTOR_REQUEST_OUT)
		FORCE_CH[31] = 1;
		step(5'h1f);
		FORCE_CH[0] = 1;
		step(5'h00);
		FORCE_CH = '0;
		ADC_DONE_IRQ = 0;
	endtask
	task t_wake();
		SRC_ENABLE = 32'h08000000;
		WAKE_PIN[6] = 1;
		repeat (2) @(negedge CLK);
		`CHK("vreq", 1'b0, VECTOR_REQUEST_OUT)
		step(5'h1b);
		SRC_ENABLE[25] = 1;
		step(5'h19);
		SRC_ENABLE = 32'h04000000;
		WAKE_RESUME = 1;
		step(5'h1a);
		SRC_ENABLE = '1;
		WAKE_PIN = '0;
		WAKE_RESUME = 0;
		repeat (3) @(negedge CLK);
	endtask
	// raise sources from low to high priority: each new one must win
	task t_sweep();
		SPARE_IRQ[1] = 1;
		step(5'h1f);
		RTC_TAMPER_IRQ = 1;
		step(5'h18);
		TWI_IRQ[5] = 1;
		step(5'h14);
		MOTOR_CONTROL_UNIT_IRQ[7] = 1;
		step(5'h0e);
		DMA_IRQ[7] = 1;
		step(5'h0c);
		TIMER_CAPTURE_EVENT[7] = 1;
		step(5'h07);
		DEBUG_TX_IRQ = 1;
		step(5'h03);
	endtask
	task close_out();
		if (fails == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		for (int c = 0; c < 16; c++) begin
			PRI_CHAN_MAP[c*4 +: 4] = c[3:0];
			SEC_CHAN_MAP[c*4 +: 4] = c[3:0];
		end
		repeat (6) @(negedge CLK);
		RST = 0;
		t_walk();
		t_chain();
		t_fast();
		t_remap();
		t_wake();
		t_sweep();
		close_out();
	end
	// the whole run needs well under a hundred cycles
	initial begin
		#20us;
		fails++;
		close_out();
	end
endmodule // cvc_top_test
